// ===== rtl/btp_ctrl.sv
// Branch target cache lookup, update and conditional branch penalty sequencer
//
// The address map and the Avalon-MM slave port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "btp_regs.svh"
module btp_ctrl
   import btp_pkg::*;
(
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic f1Valid,
   input wire logic [20:0] f1Pc,
   input wire logic pdValid,
   input wire btp_pd_s pdInfo,
   input wire logic resDecValid,
   input wire logic resIntTaken,
   input wire logic resEx2Valid,
   input wire logic resCompTaken,
   input wire logic [20:0] computedJumpTargetReg,
   input wire logic [20:0] interruptReturnTargetReg,
   input wire logic inputFlagZero,
   input wire logic inputFlagOne,
   input wire logic inputFlagTwo,
   input wire logic inputFlagThree,
   input wire logic busMasterCondition,
   output logic predHit,
   output logic [20:0] predTarget,
   output logic redirect,
   output logic [20:0] redirectPc,
   output logic penaltyValid,
   output logic [3:0] penalty
);

////////////////////////////////////////////////////////////////////////////////
// Helpers

   // Set index of an address
   function automatic logic [4:0] setOf(input logic [20:0] a);
      setOf = a[`BTP_SET_HI:`BTP_SET_LO];
   endfunction

   // Upper tag compare; low bits only place the line end inside the quad
   function automatic logic tagHit(input btp_entry_s e, input logic [20:0] a);
      tagHit = e.valid && (e.tagHi == a[`BTP_TAG_HI:`BTP_TAG_LO]);
   endfunction

   // Make a way youngest, ageing the others not older; saturates so equal ages after flush still split
   function automatic logic [7:0] touch(input logic [7:0] ag, input logic [1:0] w);
      logic [1:0] old;
      old = ag[w*2 +: 2];
      touch = ag;
      for (int i = 0; i < 4; i++) begin
         if (2'(i) != w && ag[i*2 +: 2] <= old && ag[i*2 +: 2] != 2'h3) begin
            touch[i*2 +: 2] = ag[i*2 +: 2] + 2'h1;
         end
      end
      touch[w*2 +: 2] = 2'h0;
   endfunction

   // Victim: invalid unlocked way first, else oldest unlocked way
   function automatic logic [2:0] victim(input btp_entry_s [3:0] es, input logic [7:0] ag);
      logic [2:0] best;
      logic [1:0] bestAge;
      best = 3'h0;
      bestAge = 2'h0;
      for (int i = 3; i >= 0; i--) begin
         if (!es[i].lock && !es[i].valid) begin
            best = {1'b1, 2'(i)};
         end
      end
      if (!best[2]) begin
         for (int i = 0; i < 4; i++) begin
            if (!es[i].lock && (!best[2] || ag[i*2 +: 2] > bestAge)) begin
               best = {1'b1, 2'(i)};
               bestAge = ag[i*2 +: 2];
            end
         end
      end
      victim = best;
   endfunction

////////////////////////////////////////////////////////////////////////////////
// State

   btp_state_s st_reg;
   btp_state_s st_next;
   btp_entry_s [3:0] f1Ways;
   btp_entry_s [3:0] pdWays;
   logic [2:0] f1Sel;
   logic [2:0] pdSel;
   logic [2:0] vic;
   logic [20:0] hitTgt;
   logic [20:0] pdTgt;
   logic cjAbort;
   logic pdMiss;
   logic condTaken;
   logic resNow;
   logic [3:0] pen;

   // Register readback
   function automatic logic [31:0] regRead(input btp_state_s s, input logic [3:0] a);
      unique case (a)
         `BTP_ADDR_CTRL: regRead = {30'h0, s.lockOn, s.en};
         `BTP_ADDR_STAT: regRead = {25'h0, s.penalty, s.fsm};
         `BTP_ADDR_PENTOT: regRead = s.penTotal;
         `BTP_ADDR_HITCNT: regRead = s.hitCount;
         default: regRead = 32'h0;
      endcase
   endfunction

////////////////////////////////////////////////////////////////////////////////
// Next state

   always_comb begin
      st_next = st_reg;
      st_next.predHit = 1'b0;
      st_next.redirect = 1'b0;
      st_next.penValid = 1'b0;
      st_next.waitReq = 1'b1;
      st_next.sync1 = {busMasterCondition, inputFlagThree, inputFlagTwo, inputFlagOne, inputFlagZero};
      st_next.sync2 = st_reg.sync1;
      f1Sel = 3'h0;
      pdSel = 3'h0;
      pdTgt = pdInfo.target;
      hitTgt = 21'h0;
      pen = 4'h0;
      condTaken = 1'b0;
      resNow = 1'b0;
      for (int i = 0; i < 4; i++) begin
         f1Ways[i] = st_reg.branch_target_cache[{setOf(f1Pc), 2'(i)}];
         pdWays[i] = st_reg.branch_target_cache[{setOf(pdInfo.lineEnd), 2'(i)}];
      end
      for (int i = 0; i < 4; i++) begin
         if (tagHit(f1Ways[i], f1Pc)) begin
            f1Sel = {1'b1, 2'(i)};
         end
         if (tagHit(pdWays[i], pdInfo.lineEnd)) begin
            pdSel = {1'b1, 2'(i)};
         end
      end
      vic = pdSel[2] ? pdSel : victim(pdWays, st_reg.ages[setOf(pdInfo.lineEnd)]);

      // Bus slave: one wait cycle, then answer
      if ((avs_read || avs_write) && st_reg.waitReq) begin
         st_next.waitReq = 1'b0;
         if (avs_read) begin
            st_next.rdata = regRead(st_reg, avs_address);
         end
      end
      // Writes land on the edge where the master sees the answer
      if (avs_write && !st_reg.waitReq && avs_address == `BTP_ADDR_CTRL) begin
         st_next.en = avs_writedata[`BTP_CTRL_EN];
         st_next.lockOn = avs_writedata[`BTP_CTRL_LOCK];
      end

      // First fetch stage lookup, target from live register on computed jumps
      hitTgt = f1Ways[f1Sel[1:0]].computed_jump_target_reg ? computedJumpTargetReg :
               f1Ways[f1Sel[1:0]].rti ? interruptReturnTargetReg : f1Ways[f1Sel[1:0]].target;
      if (f1Valid && st_reg.en && f1Sel[2]) begin
         st_next.predHit = 1'b1;
         st_next.predTarget = hitTgt;
         st_next.snap = hitTgt;
         st_next.hitCount = st_reg.hitCount + 32'h1;
         st_next.ages[setOf(f1Pc)] = touch(st_reg.ages[setOf(f1Pc)], f1Sel[1:0]);
         if (st_reg.lockOn) begin
            st_next.branch_target_cache[{setOf(f1Pc), f1Sel[1:0]}].lock = 1'b1;
         end
      end

      // Predecode: branch identified
      if (pdInfo.computed_jump_target_reg) begin
         pdTgt = computedJumpTargetReg;
      end else if (pdInfo.rti) begin
         pdTgt = interruptReturnTargetReg;
      end
      cjAbort = pdInfo.f1Hit && (pdInfo.computed_jump_target_reg || pdInfo.rti) && (pdTgt != st_reg.snap);
      pdMiss = !pdInfo.notPred && (!pdInfo.f1Hit || cjAbort);
      if (pdValid) begin
         st_next.pPredTaken = !pdInfo.notPred;
         st_next.pCond = pdInfo.cond;
         st_next.pTarget = pdTgt;
         st_next.pSeqPc = pdInfo.seqPc;
         st_next.pTgtCross = pdInfo.tgtCross;
         st_next.pSeqCross = pdInfo.seqCross;
         unique case (pdInfo.cond)
            BTP_C_COMP, BTP_C_BM: st_next.fsm = BTP_WAIT_EX2;
            default: st_next.fsm = BTP_WAIT_DEC;
         endcase
         if (pdMiss) begin
            // Void four fetches, five on a target crossing; jump to target regardless of condition
            st_next.redirect = 1'b1;
            st_next.redirectPc = pdTgt;
            st_next.penValid = 1'b1;
            st_next.penalty = `BTP_PEN_MISS + (pdInfo.tgtCross ? `BTP_PEN_CROSS : 4'h0);
            if (vic[2]) begin
               // Cache only predicted-taken branches
               st_next.branch_target_cache[{setOf(pdInfo.lineEnd), vic[1:0]}] = '{valid: 1'b1, lock: st_reg.lockOn,
                  computed_jump_target_reg: pdInfo.computed_jump_target_reg, rti: pdInfo.rti, absAddr: pdInfo.absAddr,
                  tagHi: pdInfo.lineEnd[`BTP_TAG_HI:`BTP_TAG_LO], tagLo: pdInfo.lineEnd[1:0],
                  target: pdInfo.target};
               st_next.ages[setOf(pdInfo.lineEnd)] = touch(st_reg.ages[setOf(pdInfo.lineEnd)], vic[1:0]);
            end
         end else if (!pdInfo.notPred && pdInfo.tgtCross) begin
            // Hit already follows the target; only a crossing costs
            st_next.penValid = 1'b1;
            st_next.penalty = `BTP_PEN_CROSS;
         end
      end

      // Condition resolution
      unique case (st_reg.pCond)
         BTP_C_INT: condTaken = resIntTaken;
         BTP_C_COMP: condTaken = resCompTaken;
         BTP_C_TRUE: condTaken = 1'b1;
         BTP_C_BM: condTaken = st_reg.sync2[4];
         default: condTaken = st_reg.sync2[st_reg.pCond[1:0]];
      endcase
      unique case (st_reg.fsm)
         BTP_WAIT_DEC: resNow = resDecValid;
         BTP_WAIT_EX2: resNow = resEx2Valid;
         default: resNow = 1'b0;
      endcase
      pen = (st_reg.fsm == BTP_WAIT_EX2) ? `BTP_PEN_EX2 : `BTP_PEN_DEC;
      if (resNow && !pdValid) begin
         st_next.fsm = BTP_IDLE;
         if (condTaken != st_reg.pPredTaken) begin
            st_next.redirect = 1'b1;
            st_next.redirectPc = condTaken ? st_reg.pTarget : st_reg.pSeqPc;
            st_next.penValid = 1'b1;
            st_next.penalty = pen + (((condTaken && st_reg.pTgtCross) ||
               (!condTaken && st_reg.pSeqCross)) ? `BTP_PEN_CROSS : 4'h0);
         end
      end
      if (st_next.penValid) begin
         st_next.penTotal = st_reg.penTotal + {28'h0, st_next.penalty};
      end

      // Full flush clears locked entries too
      if (avs_write && !st_reg.waitReq && avs_address == `BTP_ADDR_CTRL && avs_writedata[`BTP_CTRL_FLUSH]) begin
         st_next.branch_target_cache = '0;
         st_next.ages = '0;
      end
   end

////////////////////////////////////////////////////////////////////////////////
// Registers

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         st_reg <= '0;
         st_reg.en <= 1'(`BTP_CTRL_RST >> `BTP_CTRL_EN);
         st_reg.fsm <= BTP_IDLE;
         st_reg.waitReq <= 1'b1;
      end else begin
         st_reg <= st_next;
      end
   end

   // Outputs straight from flops
   assign avs_readdata = st_reg.rdata;
   assign avs_waitrequest = st_reg.waitReq;
   assign predHit = st_reg.predHit;
   assign predTarget = st_reg.predTarget;
   assign redirect = st_reg.redirect;
   assign redirectPc = st_reg.redirectPc;
   assign penaltyValid = st_reg.penValid;
   assign penalty = st_reg.penalty;

////////////////////////////////////////////////////////////////////////////////
// Checks

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!arst_n);

   sequence sMissPd;
      pdValid && pdMiss && !pdInfo.tgtCross;
   endsequence
   sequence sWaitOne;
      (avs_read || avs_write) && avs_waitrequest;
   endsequence

   a_hit_needs_enable: assert property (predHit |-> $past(st_reg.en) && $past(f1Valid))
      else $error("hit without enabled lookup");
   a_hit_no_redirect: assert property (pdValid && !pdInfo.notPred && pdInfo.f1Hit && !cjAbort
      && !resNow |=> !redirect)
      else $error("hit branch redirected");
   a_miss_four: assert property (sMissPd |=> redirect && penaltyValid && penalty == `BTP_PEN_MISS)
      else $error("miss penalty not four");
   a_miss_alloc: assert property (pdValid && pdMiss && vic[2] && !(avs_write && avs_writedata[`BTP_CTRL_FLUSH])
      |=> st_reg.branch_target_cache[{setOf($past(pdInfo.lineEnd)), $past(vic[1:0])}].valid)
      else $error("miss not allocated");
   a_computed_jump_target_reg_replay: assert property (pdValid && !pdInfo.notPred && cjAbort |=> redirect
      && redirectPc == $past(pdTgt))
      else $error("changed jump register not replayed");
   a_np_no_redirect: assert property (pdValid && pdInfo.notPred |=> !redirect)
      else $error("unpredicted branch redirected at predecode");
   a_dec_five: assert property (st_reg.fsm == BTP_WAIT_DEC && resDecValid && !pdValid
      && condTaken != st_reg.pPredTaken |=> penalty inside {`BTP_PEN_DEC, `BTP_PEN_DEC + `BTP_PEN_CROSS})
      else $error("decode mispredict not five");
   a_ex2_ten: assert property (st_reg.fsm == BTP_WAIT_EX2 && resEx2Valid && !pdValid
      && condTaken != st_reg.pPredTaken |=> penalty inside {`BTP_PEN_EX2, `BTP_PEN_EX2 + `BTP_PEN_CROSS})
      else $error("execute mispredict not ten");
   a_np_free: assert property (st_reg.fsm != BTP_IDLE && !st_reg.pPredTaken && resNow && !pdValid
      && !condTaken |=> !penaltyValid)
      else $error("correct not-taken charged");
   a_wait_one: assert property (sWaitOne |=> !avs_waitrequest ##1 avs_waitrequest)
      else $error("bus answer not after one wait");
   a_flush_clear: assert property (avs_write && !avs_waitrequest && avs_address == `BTP_ADDR_CTRL
      && avs_writedata[`BTP_CTRL_FLUSH] |=> !st_reg.branch_target_cache[0].valid && !st_reg.branch_target_cache[127].valid)
      else $error("flush left entries");

endmodule
`default_nettype wire

// ===== rtl/btp_pkg.sv
// Types shared by the branch target prediction control
package btp_pkg;
   typedef enum logic [2:0] {
      BTP_C_INT = 3'h0, BTP_C_COMP = 3'h1, BTP_C_TRUE = 3'h2, BTP_C_BM = 3'h3,
      BTP_C_F0 = 3'h4, BTP_C_F1 = 3'h5, BTP_C_F2 = 3'h6, BTP_C_F3 = 3'h7
   } btp_cond_e;
   typedef enum logic [2:0] {
      BTP_IDLE = 3'b001, BTP_WAIT_DEC = 3'b010, BTP_WAIT_EX2 = 3'b100
   } btp_fsm_e;
   typedef struct packed {
      logic valid;
      logic lock;
      logic computed_jump_target_reg;
      logic rti;
      logic absAddr;
      logic [13:0] tagHi;
      logic [1:0] tagLo;
      logic [20:0] target;
   } btp_entry_s;
   // Branch report from predecode
   typedef struct packed {
      logic [20:0] lineEnd;
      logic [20:0] target;
      logic [20:0] seqPc;
      logic notPred;
      logic f1Hit;
      logic computed_jump_target_reg;
      logic rti;
      logic absAddr;
      btp_cond_e cond;
      logic tgtCross;
      logic seqCross;
   } btp_pd_s;
   typedef struct packed {
      btp_entry_s [127:0] branch_target_cache;
      logic [31:0][7:0] ages;
      logic en;
      logic lockOn;
      logic [4:0] sync1;
      logic [4:0] sync2;
      logic [20:0] snap;
      btp_fsm_e fsm;
      logic pPredTaken;
      btp_cond_e pCond;
      logic [20:0] pTarget;
      logic [20:0] pSeqPc;
      logic pTgtCross;
      logic pSeqCross;
      logic predHit;
      logic [20:0] predTarget;
      logic redirect;
      logic [20:0] redirectPc;
      logic penValid;
      logic [3:0] penalty;
      logic [31:0] penTotal;
      logic [31:0] hitCount;
      logic waitReq;
      logic [31:0] rdata;
   } btp_state_s;
endpackage

// ===== rtl/btp_regs.svh
// Register offsets, field positions, reset values and cycle counts of the branch predictor
`ifndef BTP_REGS_SVH
`define BTP_REGS_SVH
`define BTP_ADDR_CTRL 4'h0
`define BTP_ADDR_STAT 4'h4
`define BTP_ADDR_PENTOT 4'h8
`define BTP_ADDR_HITCNT 4'hc
`define BTP_CTRL_EN 0
`define BTP_CTRL_LOCK 1
`define BTP_CTRL_FLUSH 2
`define BTP_CTRL_RST 2'h1
`define BTP_SET_HI 6
`define BTP_SET_LO 2
`define BTP_TAG_HI 20
`define BTP_TAG_LO 7
`define BTP_PEN_MISS 4'h4
`define BTP_PEN_DEC 4'h5
`define BTP_PEN_EX2 4'ha
`define BTP_PEN_CROSS 4'h1
`endif

// ===== tb/btp_qmem_model.sv
// Instruction memory model handing out aligned quad word fetch addresses
`timescale 1ns/1ps
`default_nettype none
module btp_qmem_model (
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic load,
   input wire logic [20:0] startPc,
   input wire logic fetchEn,
   input wire logic predHit,
   input wire logic [20:0] predTarget,
   output logic f1Valid,
   output logic [20:0] f1Pc
);
   logic [20:0] pcReg;
   // Fetch pointer, jumps to a cached target after a hit
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         pcReg <= 21'h0;
      end else if (load) begin
         pcReg <= {startPc[20:2], 2'h0};
      end else if (predHit) begin
         pcReg <= {predTarget[20:2], 2'h0};
      end else if (fetchEn) begin
         pcReg <= pcReg + 21'h4;
      end
   end
   // Idle address is inverted so no stale value looks valid
   assign f1Valid = fetchEn;
   assign f1Pc = fetchEn ? pcReg : ~pcReg;
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
// Self-checking bench for the branch target prediction control
`timescale 1ns/1ps
`default_nettype none
`include "btp_regs.svh"
module tb_top
   import btp_pkg::*;
;
   logic core_clk, arst_n, avs_read, avs_write, avs_waitrequest, f1Valid, pdValid, load, fetchEn;
   logic resDecValid, resIntTaken, resEx2Valid, resCompTaken, predHit, redirect, penaltyValid;
   logic inputFlagZero, inputFlagOne, inputFlagTwo, inputFlagThree, busMasterCondition;
   logic [3:0] avs_address;
   logic [3:0] penalty;
   logic [31:0] avs_writedata, avs_readdata, rd;
   logic [20:0] f1Pc, startPc, computedJumpTargetReg, interruptReturnTargetReg, predTarget, redirectPc;
   btp_pd_s pdInfo;
   int fails, testsRun;
   ////////////////////////////////////////
   // Design and fetch memory model
   btp_ctrl u_btp_ctrl (
      .core_clk(core_clk), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .f1Valid(f1Valid), .f1Pc(f1Pc), .pdValid(pdValid),
      .pdInfo(pdInfo), .resDecValid(resDecValid), .resIntTaken(resIntTaken), .resEx2Valid(resEx2Valid),
      .resCompTaken(resCompTaken), .computedJumpTargetReg(computedJumpTargetReg),
      .interruptReturnTargetReg(interruptReturnTargetReg), .inputFlagZero(inputFlagZero), .inputFlagOne(inputFlagOne),
      .inputFlagTwo(inputFlagTwo), .inputFlagThree(inputFlagThree), .busMasterCondition(busMasterCondition),
      .predHit(predHit), .predTarget(predTarget), .redirect(redirect), .redirectPc(redirectPc),
      .penaltyValid(penaltyValid), .penalty(penalty)
   );
   btp_qmem_model u_btp_qmem_model (
      .core_clk(core_clk), .arst_n(arst_n), .load(load), .startPc(startPc), .fetchEn(fetchEn),
      .predHit(predHit), .predTarget(predTarget), .f1Valid(f1Valid), .f1Pc(f1Pc)
   );
   ////////////////////////////////////////
   // Shared compare, bus and pipeline tasks
   task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      testsRun++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task chkOut(input logic expR, input logic [20:0] expPc, input logic [3:0] expPen);
      check("redirect", {31'h0, redirect}, {31'h0, expR});
      check("penaltyValid", {31'h0, penaltyValid}, {31'h0, expPen != 4'h0});
      if (expR) check("redirectPc", {11'h0, redirectPc}, {11'h0, expPc});
      if (expPen != 4'h0) check("penalty", {28'h0, penalty}, {28'h0, expPen});
   endtask
   task busXfer(input logic wr, input logic [3:0] addr, input logic [31:0] data);
      int n;
      n = 0;
      @(posedge core_clk);
      avs_address <= addr;
      avs_write <= wr;
      avs_read <= !wr;
      avs_writedata <= data;
      @(posedge core_clk);
      while (avs_waitrequest !== 1'b0 && n < 20) begin
         @(posedge core_clk);
         n++;
      end
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (n >= 20) fails++;
   endtask
   function btp_pd_s mkPd(input logic [20:0] le, input logic [20:0] tg, input logic np, input logic hit,
         input btp_cond_e cd, input logic tc, input logic sc, input logic cj);
      return '{lineEnd: le, target: tg, seqPc: le + 21'h1, notPred: np, f1Hit: hit, computed_jump_target_reg: cj, rti: 1'b0,
         absAddr: 1'b0, cond: cd, tgtCross: tc, seqCross: sc};
   endfunction
   task sendPd(input btp_pd_s info, input logic expR, input logic [20:0] expPc, input logic [3:0] expPen);
      @(posedge core_clk);
      pdValid <= 1'b1;
      pdInfo <= info;
      @(posedge core_clk);
      pdValid <= 1'b0;
      #1 chkOut(expR, expPc, expPen);
   endtask
   task res(input logic ex, input logic tk, input logic expR, input logic [20:0] expPc, input logic [3:0] expPen);
      @(posedge core_clk);
      resDecValid <= !ex;
      resEx2Valid <= ex;
      resIntTaken <= tk;
      resCompTaken <= tk;
      @(posedge core_clk);
      resDecValid <= 1'b0;
      resEx2Valid <= 1'b0;
      #1 chkOut(expR, expPc, expPen);
   endtask
   task lookup(input logic [20:0] addr, input logic expHit, input logic [20:0] expTgt);
      @(posedge core_clk);
      startPc <= addr;
      load <= 1'b1;
      @(posedge core_clk);
      load <= 1'b0;
      fetchEn <= 1'b1;
      @(posedge core_clk);
      fetchEn <= 1'b0;
      #1 check("predHit", {31'h0, predHit}, {31'h0, expHit});
      if (expHit) check("predTarget", {11'h0, predTarget}, {11'h0, expTgt});
   endtask
   ////////////////////////////////////////
   // Miss, allocation, hit and crossing costs
   task testMiss();
      lookup(21'h00100, 1'b0, 21'h0);
      sendPd(mkPd(21'h00100, 21'h00440, 1'b0, 1'b0, BTP_C_INT, 1'b0, 1'b0, 1'b0), 1'b1, 21'h00440, 4'h4);
      res(1'b0, 1'b1, 1'b0, 21'h0, 4'h0);
      lookup(21'h00100, 1'b1, 21'h00440);
      sendPd(mkPd(21'h00184, 21'h00800, 1'b0, 1'b0, BTP_C_COMP, 1'b1, 1'b0, 1'b0), 1'b1, 21'h00800, 4'h5);
      res(1'b1, 1'b1, 1'b0, 21'h0, 4'h0);
      sendPd(mkPd(21'h00100, 21'h00440, 1'b0, 1'b1, BTP_C_INT, 1'b0, 1'b0, 1'b0), 1'b0, 21'h0, 4'h0);
      sendPd(mkPd(21'h00100, 21'h00440, 1'b0, 1'b1, BTP_C_INT, 1'b1, 1'b0, 1'b0), 1'b0, 21'h0, 4'h1);
   endtask
   // Wrong guesses in both directions
   task testMispredict();
      sendPd(mkPd(21'h00208, 21'h00600, 1'b0, 1'b0, BTP_C_INT, 1'b0, 1'b1, 1'b0), 1'b1, 21'h00600, 4'h4);
      res(1'b0, 1'b0, 1'b1, 21'h00209, 4'h6);
      sendPd(mkPd(21'h00100, 21'h00440, 1'b0, 1'b1, BTP_C_COMP, 1'b0, 1'b0, 1'b0), 1'b0, 21'h0, 4'h0);
      res(1'b1, 1'b0, 1'b1, 21'h00101, 4'ha);
      sendPd(mkPd(21'h0030c, 21'h00700, 1'b1, 1'b0, BTP_C_INT, 1'b1, 1'b0, 1'b0), 1'b0, 21'h0, 4'h0);
      res(1'b0, 1'b1, 1'b1, 21'h00700, 4'h6);
      lookup(21'h0030c, 1'b0, 21'h0);
      sendPd(mkPd(21'h0030c, 21'h00700, 1'b1, 1'b0, BTP_C_INT, 1'b0, 1'b0, 1'b0), 1'b0, 21'h0, 4'h0);
      res(1'b0, 1'b0, 1'b0, 21'h0, 4'h0);
   endtask
   // Every condition source resolved at its own stage only
   task testStages();
      logic ex;
      for (int c = 0; c < 8; c++) begin
         ex = (c == BTP_C_COMP) || (c == BTP_C_BM);
         // Only the pin under test is high, so a wrong pin pick shows
         @(posedge core_clk);
         {busMasterCondition, inputFlagThree, inputFlagTwo, inputFlagOne, inputFlagZero} <= (c == BTP_C_BM) ? 5'h10 :
            (c >= 4) ? 5'(1 << (c - 4)) : 5'h00;
         sendPd(mkPd(21'h00410, 21'h00a00, 1'b1, 1'b0, btp_cond_e'(c), 1'b0, 1'b0, 1'b0), 1'b0, 21'h0, 4'h0);
         res(!ex, 1'b1, 1'b0, 21'h0, 4'h0);
         res(ex, 1'b1, 1'b1, 21'h00a00, ex ? 4'ha : 4'h5);
      end
   endtask
   // Computed jump target taken live, replay on change
   task testCjmp();
      btp_pd_s p;
      @(posedge core_clk);
      computedJumpTargetReg <= 21'h01234;
      sendPd(mkPd(21'h00520, 21'h01234, 1'b0, 1'b0, BTP_C_TRUE, 1'b0, 1'b0, 1'b1), 1'b1, 21'h01234, 4'h4);
      @(posedge core_clk);
      computedJumpTargetReg <= 21'h01300;
      lookup(21'h00520, 1'b1, 21'h01300);
      sendPd(mkPd(21'h00520, 21'h01300, 1'b0, 1'b1, BTP_C_TRUE, 1'b0, 1'b0, 1'b1), 1'b0, 21'h0, 4'h0);
      lookup(21'h00520, 1'b1, 21'h01300);
      @(posedge core_clk);
      computedJumpTargetReg <= 21'h01500;
      sendPd(mkPd(21'h00520, 21'h01500, 1'b0, 1'b1, BTP_C_TRUE, 1'b0, 1'b0, 1'b1), 1'b1, 21'h01500, 4'h4);
      // Interrupt return target also read live on a hit
      @(posedge core_clk);
      interruptReturnTargetReg <= 21'h01600;
      p = mkPd(21'h00624, 21'h01600, 1'b0, 1'b0, BTP_C_TRUE, 1'b0, 1'b0, 1'b0);
      p.rti = 1'b1;
      sendPd(p, 1'b1, 21'h01600, 4'h4);
      @(posedge core_clk);
      interruptReturnTargetReg <= 21'h01640;
      lookup(21'h00624, 1'b1, 21'h01640);
   endtask
   // Replacement order, locking, enable and flush; branch lines sit in separate quad words
   task testWays();
      for (int i = 1; i < 6; i++) begin
         sendPd(mkPd(21'h14 | (21'(i) << 7), 21'h100 + 21'(i), 1'b0, 1'b0, BTP_C_INT, 1'b0, 1'b0, 1'b0),
            1'b1, 21'h100 + 21'(i), 4'h4);
      end
      lookup(21'h00094, 1'b0, 21'h0);
      lookup(21'h00294, 1'b1, 21'h00105);
      lookup(21'h00114, 1'b1, 21'h00102);
      sendPd(mkPd(21'h00314, 21'h00106, 1'b0, 1'b0, BTP_C_INT, 1'b0, 1'b0, 1'b0), 1'b1, 21'h00106, 4'h4);
      lookup(21'h00194, 1'b0, 21'h0);
      lookup(21'h00294, 1'b1, 21'h00105);
      busXfer(1'b1, `BTP_ADDR_CTRL, 32'h3);
      busXfer(1'b0, `BTP_ADDR_CTRL, 32'h0);
      check("ctrlLock", rd, 32'h3);
      for (int i = 1; i < 5; i++) begin
         sendPd(mkPd(21'h18 | (21'(i) << 7), 21'h200 + 21'(i), 1'b0, 1'b0, BTP_C_INT, 1'b0, 1'b0, 1'b0),
            1'b1, 21'h200 + 21'(i), 4'h4);
      end
      busXfer(1'b1, `BTP_ADDR_CTRL, 32'h1);
      sendPd(mkPd(21'h00298, 21'h00205, 1'b0, 1'b0, BTP_C_INT, 1'b0, 1'b0, 1'b0), 1'b1, 21'h00205, 4'h4);
      lookup(21'h00298, 1'b0, 21'h0);
      lookup(21'h00098, 1'b1, 21'h00201);
      busXfer(1'b1, `BTP_ADDR_CTRL, 32'h0);
      lookup(21'h00118, 1'b0, 21'h0);
      busXfer(1'b1, `BTP_ADDR_CTRL, 32'h5);
      lookup(21'h00098, 1'b0, 21'h0);
      busXfer(1'b0, `BTP_ADDR_CTRL, 32'h0);
      check("ctrlAfterFlush", rd, 32'h1);
   endtask
   ////////////////////////////////////////
   // Verdict and end of run
   task stop_test();
      if (fails == 0 && testsRun > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // Clock
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   // Watchdog
   initial begin
      #400000;
      fails++;
      stop_test();
   end
   // Main sequence
   initial begin
      {arst_n, avs_read, avs_write, pdValid, load, fetchEn, resDecValid, resIntTaken} = 8'h0;
      {resEx2Valid, resCompTaken, inputFlagZero, inputFlagOne, inputFlagTwo, inputFlagThree} = 6'h0;
      busMasterCondition = 1'b0;
      avs_address = 4'h0;
      avs_writedata = 32'h0;
      startPc = 21'h0;
      computedJumpTargetReg = 21'h0;
      interruptReturnTargetReg = 21'h0;
      pdInfo = '0;
      @(posedge core_clk);
      #1 check("resetWait", {31'h0, avs_waitrequest}, 32'h1);
      @(posedge core_clk);
      arst_n <= 1'b1;
      busXfer(1'b0, `BTP_ADDR_CTRL, 32'h0);
      check("ctrlReset", rd, 32'h1);
      busXfer(1'b0, `BTP_ADDR_STAT, 32'h0);
      check("statReset", rd, 32'h1);
      busXfer(1'b0, 4'h2, 32'h0);
      check("unmapped", rd, 32'h0);
      testMiss();
      testMispredict();
      testStages();
      testCjmp();
      testWays();
      stop_test();
   end
endmodule
`default_nettype wire
